// ---- src/jspe_scan_dev.sv ----
// Purpose: Scan packet engine driving a test access port
// Assumes: Runs on the link clock; command bytes arrive by handshake
// Notes:   One TCK period is two HALF spans of link clock cycles
`timescale 1ns/100ps
module jspe_scan_dev
  import jspe_pkg::*;
#(
  parameter int HALF = TCK_HALF
) (
  input  wire logic link_clk_i,
  input  wire logic resetn_i,
  input  wire logic clk_en_i,
  input  wire logic tdo_i,
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  jspe_link_if.dev  lnk
);
  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  localparam int PHW = $clog2(2 * HALF);
  localparam logic [PHW-1:0] PH_RISE = PHW'(HALF - 1);
  localparam logic [PHW-1:0] PH_FALL = PHW'(2 * HALF - 1);

  if (HALF < 2) begin : g_chk
    $error("HALF must be at least 2");
  end

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  jspe_state_e       state_q;
  logic              fixed_q;
  logic              tdi_fix_q;
  logic              tms_last_q;
  logic              capt_q;
  logic              need_data_q;
  logic [REM_W-1:0]  rem_q;
  logic [2:0]        bi_q;
  logic [BYTE_W-1:0] tdi_buf_q;
  logic [BYTE_W-1:0] cap_q;
  logic [PHW-1:0]    ph_q;
  logic              cmd_ack_q;
  logic              rsp_tgl_q;
  logic [BYTE_W-1:0] rsp_byte_q;
  logic              busy_q;
  logic              cmd_tgl_s;
  logic              rsp_ack_s;
  logic              tdo_s;
  logic              cmd_new;
  logic              taking;
  logic              rsp_free;
  logic              tick_rise;
  logic              tick_fall;
  logic              last_bit;
  logic              byte_end;
  logic [BYTE_W-1:0] in_byte;
  logic [2:0]        plen;

  // Highest set bit of the packed start field, zero if none
  function automatic logic [2:0] f_plen(input logic [5:0] f);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 6; i++) begin
      if (f[i]) begin
        n = 3'(i + 1);
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // Crossing from the controller and the TDO pin
  // ----------------------------------------------------------------
  jspe_sync #(
    .W (3)
  ) u_sync (
    .clk_i    (link_clk_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .d_i      ({lnk.cmd_tgl, lnk.rsp_ack, tdo_i}),
    .q_o      ({cmd_tgl_s, rsp_ack_s, tdo_s})
  );

  // Decode helpers
  assign in_byte   = lnk.cmd_byte;
  assign cmd_new   = cmd_tgl_s != cmd_ack_q;
  assign taking    = cmd_new && (state_q == ST_IDLE ||
                     state_q == ST_LEN || state_q == ST_DATA);
  assign rsp_free  = rsp_tgl_q == rsp_ack_s;
  assign tick_rise = state_q == ST_SHIFT && ph_q == PH_RISE;
  assign tick_fall = state_q == ST_SHIFT && ph_q == PH_FALL;
  assign last_bit  = rem_q == REM_W'(1);
  assign byte_end  = bi_q == BYTE_LAST;
  assign plen      = f_plen(in_byte[6:1]);

  // Link outputs
  assign lnk.cmd_ack  = cmd_ack_q;
  assign lnk.rsp_tgl  = rsp_tgl_q;
  assign lnk.rsp_byte = rsp_byte_q;
  assign lnk.busy     = busy_q;

  // ----------------------------------------------------------------
  // Packet parsing and scan sequencing
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_q     <= ST_IDLE;
      fixed_q     <= 1'b0;
      tdi_fix_q   <= 1'b0;
      tms_last_q  <= 1'b0;
      capt_q      <= 1'b0;
      need_data_q <= 1'b0;
      rem_q       <= '0;
      bi_q        <= 3'h0;
      tdi_buf_q   <= '0;
    end else if (clk_en_i) begin
      case (state_q)
        ST_IDLE: begin
          // Other packet types are dropped here
          if (taking && in_byte[7:OPC_TAG_LO] == OPC_TAG) begin
            fixed_q    <= in_byte[OPC_FIXED];
            tdi_fix_q  <= in_byte[OPC_TDI];
            tms_last_q <= in_byte[OPC_TMS];
            capt_q     <= in_byte[OPC_CAPT];
            bi_q       <= 3'h0;
            state_q    <= ST_LEN;
          end
        end
        ST_LEN: begin
          if (taking) begin
            tdi_buf_q <= in_byte;
            if (in_byte[LEN_PACKED]) begin
              // Packed: packet ends here
              need_data_q <= 1'b0;
              rem_q       <= REM_W'(plen);
              state_q     <= (plen == 3'h0) ? ST_IDLE : ST_SHIFT;
            end else begin
              // Normal: field holds length minus one
              rem_q       <= REM_W'(in_byte[6:0]) + REM_W'(1);
              need_data_q <= !fixed_q;
              state_q     <= fixed_q ? ST_SHIFT : ST_DATA;
            end
          end
        end
        ST_DATA: begin
          // One data byte per eight scan bits
          if (taking) begin
            tdi_buf_q <= in_byte;
            state_q   <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick_fall) begin
            rem_q <= rem_q - REM_W'(1);
            bi_q  <= bi_q + 3'h1;
            if (capt_q && (last_bit || byte_end)) begin
              state_q <= ST_PUSH;
            end else if (last_bit) begin
              state_q <= ST_IDLE;
            end else if (byte_end && need_data_q) begin
              state_q <= ST_DATA;
            end
          end
        end
        ST_PUSH: begin
          // TCK stays low until the response slot frees
          if (rsp_free) begin
            if (rem_q == '0) begin
              state_q <= ST_IDLE;
            end else if (need_data_q) begin
              state_q <= ST_DATA;
            end else begin
              state_q <= ST_SHIFT;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // TCK phase counter
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ph_q <= '0;
    end else if (clk_en_i) begin
      if (state_q != ST_SHIFT || tick_fall) begin
        ph_q <= '0;
      end else begin
        ph_q <= ph_q + PHW'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Test access port pins
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tck_o <= 1'b0;
      tms_o <= 1'b0;
      tdi_o <= 1'b0;
    end else if (clk_en_i) begin
      if (tick_rise) begin
        tck_o <= 1'b1;
      end else if (tick_fall || state_q != ST_SHIFT) begin
        tck_o <= 1'b0;
      end
      if (state_q == ST_SHIFT && ph_q == '0) begin
        tms_o <= last_bit && tms_last_q;
        tdi_o <= fixed_q ? tdi_fix_q : tdi_buf_q[bi_q];
      end else if (state_q == ST_IDLE) begin
        tms_o <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // TDO capture, value stored only and never decoded
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cap_q <= '0;
    end else if (clk_en_i) begin
      if (state_q == ST_IDLE || (state_q == ST_PUSH && rsp_free)) begin
        cap_q <= '0;
      end else if (tick_fall && capt_q) begin
        cap_q[bi_q] <= tdo_s;
      end
    end
  end

  // ----------------------------------------------------------------
  // Handshake toward the controller
  // ----------------------------------------------------------------
  always_ff @(posedge link_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_ack_q  <= 1'b0;
      rsp_tgl_q  <= 1'b0;
      rsp_byte_q <= '0;
      busy_q     <= 1'b0;
    end else if (clk_en_i) begin
      if (taking) begin
        cmd_ack_q <= cmd_tgl_s;
      end
      if (state_q == ST_PUSH && rsp_free) begin
        rsp_byte_q <= cap_q;
        rsp_tgl_q  <= !rsp_tgl_q;
      end
      busy_q <= state_q != ST_IDLE;
    end
  end
endmodule

// ---- pkg/jspe_pkg.sv ----
// Purpose: Shared constants and types of the scan packet engine
// Assumes: Byte wide command and response streams
// Notes:   Offsets are byte addresses on the AHB-Lite register bus
package jspe_pkg;
  // ----------------------------------------------------------------
  // Packet byte layout
  // ----------------------------------------------------------------
  localparam int          BYTE_W      = 8;
  localparam int          REM_W       = 8;
  localparam logic [2:0]  OPC_TAG     = 3'h4;
  localparam int          OPC_TAG_LO  = 5;
  localparam int          OPC_TMS     = 3;
  localparam int          OPC_CAPT    = 2;
  localparam int          OPC_TDI     = 1;
  localparam int          OPC_FIXED   = 0;
  localparam int          LEN_PACKED  = 7;
  localparam logic [2:0]  BYTE_LAST   = 3'h7;
  // ----------------------------------------------------------------
  // Link timing, in link clock cycles per half TCK period
  // ----------------------------------------------------------------
  localparam int          TCK_HALF    = 2;
  // ----------------------------------------------------------------
  // Controller registers and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CMD     = 8'h00;
  localparam logic [7:0]  REG_RSP     = 8'h04;
  localparam logic [7:0]  REG_STAT    = 8'h08;
  localparam int          RSP_VLD_BIT = 8;
  localparam int          ST_CMD_FULL = 0;
  localparam int          ST_RSP_VLD  = 1;
  localparam int          ST_BUSY     = 2;
  // ----------------------------------------------------------------
  // Engine states, Gray along the usual path
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h0,
    ST_LEN   = 3'h1,
    ST_DATA  = 3'h3,
    ST_SHIFT = 3'h2,
    ST_PUSH  = 3'h6
  } jspe_state_e;
endpackage

// ---- pkg/jspe_link_if.sv ----
// Purpose: Toggle handshake link between controller and scan engine
// Assumes: Data words stay stable while their toggle is unanswered
// Notes:   Receivers synchronise the toggles and busy level
`timescale 1ns/100ps
interface jspe_link_if;
  logic       cmd_tgl;
  logic [7:0] cmd_byte;
  logic       cmd_ack;
  logic       rsp_tgl;
  logic [7:0] rsp_byte;
  logic       rsp_ack;
  logic       busy;

  modport dev (
    input  cmd_tgl,
    input  cmd_byte,
    input  rsp_ack,
    output cmd_ack,
    output rsp_tgl,
    output rsp_byte,
    output busy
  );
  modport host (
    output cmd_tgl,
    output cmd_byte,
    output rsp_ack,
    input  cmd_ack,
    input  rsp_tgl,
    input  rsp_byte,
    input  busy
  );
endinterface

// ---- src/jspe_sync.sv ----
// Purpose: Two flip-flop synchroniser for a group of levels
// Assumes: Each bit changes independently and slowly
// Notes:   First stage feeds only the second stage
`timescale 1ns/100ps
module jspe_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         resetn_i,
  input  wire logic         clk_en_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_q;

  // Two stage capture
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else if (clk_en_i) begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end
endmodule

// ---- src/jspe_scan_host.sv ----
// Purpose: AHB-Lite controller feeding the scan engine
// Assumes: Single slave, word transfers, zero wait states
// Notes:   Writes to a full command slot are dropped
`timescale 1ns/100ps
module jspe_scan_host
  import jspe_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  jspe_link_if.host        lnk
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              cmd_tgl_q;
  logic [BYTE_W-1:0] cmd_byte_q;
  logic              rsp_ack_q;
  logic              wr_pend_q;
  logic [7:0]        wr_addr_q;
  logic              cmd_ack_s;
  logic              rsp_tgl_s;
  logic              busy_s;
  logic              aphase;
  logic              cmd_full;
  logic              rsp_vld;
  logic [31:0]       rd_val;

  // Crossing from the engine
  jspe_sync #(
    .W (3)
  ) u_sync (
    .clk_i    (clock_i),
    .resetn_i (resetn_i),
    .clk_en_i (clk_en_i),
    .d_i      ({lnk.cmd_ack, lnk.rsp_tgl, lnk.busy}),
    .q_o      ({cmd_ack_s, rsp_tgl_s, busy_s})
  );

  // Bus decode and slot state
  assign aphase   = hsel_i && htrans_i[1] && hready_i;
  assign cmd_full = cmd_tgl_q != cmd_ack_s;
  assign rsp_vld  = rsp_tgl_s != rsp_ack_q;

  assign lnk.cmd_tgl  = cmd_tgl_q;
  assign lnk.cmd_byte = cmd_byte_q;
  assign lnk.rsp_ack  = rsp_ack_q;

  // Read data selection
  always_comb begin
    rd_val = 32'h0000_0000;
    case (haddr_i[7:0])
      REG_RSP: begin
        rd_val[RSP_VLD_BIT] = rsp_vld;
        rd_val[7:0]         = rsp_vld ? lnk.rsp_byte : 8'h00;
      end
      REG_STAT: begin
        rd_val[ST_CMD_FULL] = cmd_full;
        rd_val[ST_RSP_VLD]  = rsp_vld;
        rd_val[ST_BUSY]     = busy_s;
      end
      default: begin
        rd_val = 32'h0000_0000;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_q   <= 1'b0;
      wr_addr_q   <= 8'h00;
      hrdata_o    <= 32'h0000_0000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else if (clk_en_i) begin
      wr_pend_q   <= aphase && hwrite_i;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
      if (aphase) begin
        wr_addr_q <= haddr_i[7:0];
        if (!hwrite_i) begin
          hrdata_o <= rd_val;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Command send and response pop
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cmd_tgl_q  <= 1'b0;
      cmd_byte_q <= '0;
      rsp_ack_q  <= 1'b0;
    end else if (clk_en_i) begin
      if (wr_pend_q && wr_addr_q == REG_CMD && !cmd_full) begin
        cmd_byte_q <= hwdata_i[7:0];
        cmd_tgl_q  <= !cmd_tgl_q;
      end
      if (aphase && !hwrite_i && haddr_i[7:0] == REG_RSP && rsp_vld) begin
        rsp_ack_q <= rsp_tgl_s;
      end
    end
  end
endmodule

// ---- sim/jspe_link_monitor.sv ----
// Purpose: Checks on the scan link and the scan pins
// Assumes: Link clock domain, HALF of 2
// Notes:   Takes the interface signals as plain inputs
`timescale 1ns/100ps
module jspe_link_monitor (
  input wire logic       link_clk_i,
  input wire logic       resetn_i,
  input wire logic       cmd_tgl,
  input wire logic [7:0] cmd_byte,
  input wire logic       cmd_ack,
  input wire logic       rsp_tgl,
  input wire logic [7:0] rsp_byte,
  input wire logic       rsp_ack,
  input wire logic       busy,
  input wire logic       tck_o,
  input wire logic       tms_o,
  input wire logic       tdi_o
);
  // ----------------------------------------------------------------
  // Clocking and sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (!resetn_i);
  // High half of one TCK period
  sequence s_tck_high;
    tck_o [*2] ##1 !tck_o;
  endsequence
  // Low half of one TCK period
  sequence s_tck_low;
    !tck_o [*2];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  chk_tck_high_span: assert property ($rose(tck_o) |-> s_tck_high)
    else $error("tck high span wrong");
  chk_tck_low_span: assert property ($fell(tck_o) |-> s_tck_low)
    else $error("tck low span wrong");
  chk_pins_stable: assert property
    (tck_o |-> $stable(tdi_o) && $stable(tms_o))
    else $error("tdi or tms moved while tck high");
  chk_idle_tck: assert property (!busy |-> !tck_o)
    else $error("tck high while idle");
  chk_cmd_stable: assert property
    ((cmd_tgl != cmd_ack) && $stable(cmd_tgl) |-> $stable(cmd_byte))
    else $error("command byte moved while pending");
  chk_rsp_stable: assert property
    ((rsp_tgl != rsp_ack) && $stable(rsp_tgl) |-> $stable(rsp_byte))
    else $error("response byte moved while pending");
  chk_rsp_in_scan: assert property ($changed(rsp_tgl) |-> $past(busy))
    else $error("response outside a scan");
  chk_ack_bound: assert property
    ($changed(cmd_tgl) |-> ##[1:1000] (cmd_ack == cmd_tgl))
    else $error("command byte never taken");
  chk_tms_last: assert property
    ($fell(tck_o) && tms_o |=> !tck_o [*4])
    else $error("tms high before the last bit");
endmodule

// ---- sim/jspe_scan_packet_engine_tb.sv ----
// Purpose: Bench driving scan packets over AHB-Lite
// Assumes: TDO looped back from TDI, one response slot
// Notes:   Pins recorded at each TCK rising edge
`timescale 1ns/100ps
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin \
  fail_count++; $display("ERROR %s expected %0h seen %0h", nm, ex, gt); \
  end end
module jspe_scan_packet_engine_tb;
  import jspe_pkg::*;
  logic         clock_i = 1'b0;
  logic         link_clk_i = 1'b0;
  logic         resetn_i = 1'b0;
  logic [31:0]  haddr = 32'h0;
  logic [1:0]   htrans = 2'h0;
  logic         hwrite = 1'b0;
  logic [31:0]  hwdata = 32'h0;
  logic [31:0]  hrdata;
  logic         hreadyout;
  logic         hresp;
  logic         tck_o;
  logic         tms_o;
  logic         tdi_o;
  logic [127:0] tdi_seen;
  logic [127:0] tms_seen;
  int           nbits = 0;
  int           fail_count = 0;
  int           checks = 0;
  int           cyc = 0;
  logic [31:0]  r;

  // Clocks, unrelated in phase
  always #2.5 clock_i = ~clock_i;
  always #3 link_clk_i = ~link_clk_i;

  jspe_link_if jspe_link_if_inst ();
  jspe_scan_host jspe_scan_host_inst (
    .clock_i     (clock_i),
    .resetn_i    (resetn_i),
    .clk_en_i    (1'b1),
    .hsel_i      (1'b1),
    .haddr_i     (haddr),
    .htrans_i    (htrans),
    .hwrite_i    (hwrite),
    .hsize_i     (3'h2),
    .hwdata_i    (hwdata),
    .hready_i    (hreadyout),
    .hrdata_o    (hrdata),
    .hreadyout_o (hreadyout),
    .hresp_o     (hresp),
    .lnk         (jspe_link_if_inst)
  );
  jspe_scan_dev jspe_scan_dev_inst (
    .link_clk_i (link_clk_i),
    .resetn_i   (resetn_i),
    .clk_en_i   (1'b1),
    .tdo_i      (tdi_o),
    .tck_o      (tck_o),
    .tms_o      (tms_o),
    .tdi_o      (tdi_o),
    .lnk        (jspe_link_if_inst)
  );
  jspe_link_monitor jspe_link_monitor_inst (
    .link_clk_i (link_clk_i),
    .resetn_i   (resetn_i),
    .cmd_tgl    (jspe_link_if_inst.cmd_tgl),
    .cmd_byte   (jspe_link_if_inst.cmd_byte),
    .cmd_ack    (jspe_link_if_inst.cmd_ack),
    .rsp_tgl    (jspe_link_if_inst.rsp_tgl),
    .rsp_byte   (jspe_link_if_inst.rsp_byte),
    .rsp_ack    (jspe_link_if_inst.rsp_ack),
    .busy       (jspe_link_if_inst.busy),
    .tck_o      (tck_o),
    .tms_o      (tms_o),
    .tdi_o      (tdi_o)
  );

  // Record the wire at each TCK rising edge
  always @(posedge tck_o) begin
    if (nbits < 128) begin
      tdi_seen[nbits] = tdi_o;
      tms_seen[nbits] = tms_o;
    end
    nbits++;
  end

  // Verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  // One single AHB-Lite word transfer
  task automatic bus(input logic wr, input logic [31:0] a, wd,
                     output logic [31:0] rd);
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clock_i); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  // One command byte once the slot is free
  task automatic put(input logic [7:0] b);
    logic [31:0] s;
    do bus(1'b0, {24'h0, REG_STAT}, 32'h0, s);
    while (s[ST_CMD_FULL] !== 1'b0);
    bus(1'b1, {24'h0, REG_CMD}, {24'h0, b}, s);
  endtask

  // Scan length from the length byte
  function automatic int scan_len(input logic [7:0] lb);
    if (!lb[7]) return int'(lb[6:0]) + 1;
    for (int i = 6; i >= 1; i--) if (lb[i]) return i;
    return 0;
  endfunction

  // One response byte, with the stall check before the first
  task automatic take(input int k, input int n, input logic [127:0] e);
    if (k == 0) begin
      repeat (150) @(posedge clock_i);
      `CHK("stall bits", (n > 16) ? 16 : n, nbits)
    end
    do bus(1'b0, {24'h0, REG_RSP}, 32'h0, r);
    while (r[RSP_VLD_BIT] !== 1'b1);
    `CHK("rsp byte", e[8*k+:8], r[7:0])
  endtask

  // One packet, its responses and its wire pattern
  task automatic scan(input logic [7:0] op, lb, input logic [127:0] d);
    int n;
    int nb;
    logic [127:0] m;
    logic [127:0] e;
    logic [127:0] t;
    int           rk;
    n = scan_len(lb);
    nb = (n + 7) / 8;
    m = (n == 128) ? {128{1'b1}} : (128'h1 << n) - 128'h1;
    e = (op[0] ? {128{op[1]}} : (lb[7] ? {122'h0, lb[5:0]} : d)) & m;
    t = op[3] ? (128'h1 << (n - 1)) : 128'h0;
    nbits = 0;
    rk = 0;
    put(op);
    put(lb);
    // Responses drain behind the data so a stalled scan moves on
    if (!lb[7] && !op[0]) for (int k = 0; k < nb; k++) begin
      if (op[2] && k >= 2) begin
        take(rk, n, e);
        rk++;
      end
      put(e[8*k+:8]);
    end
    while (op[2] && rk < nb) begin
      take(rk, n, e);
      rk++;
    end
    while (nbits < n) @(posedge clock_i);
    do bus(1'b0, {24'h0, REG_STAT}, 32'h0, r);
    while (r[ST_BUSY] !== 1'b0);
    bus(1'b0, {24'h0, REG_RSP}, 32'h0, r);
    `CHK("extra rsp", 1'b0, r[RSP_VLD_BIT])
    `CHK("scan bits", n, nbits)
    `CHK("tdi", e, tdi_seen & m)
    `CHK("tms", t, tms_seen & m)
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    @(posedge clock_i);
    bus(1'b0, 32'h0000_0040, 32'h0, r);
    `CHK("unmapped", 32'h0, r)
    put(8'h5A);
    scan(8'h8C, 8'h14, 128'h15A5C3);
    scan(8'h84, 8'h7F, {4{32'hC3A5_96E1}});
    scan(8'h8C, 8'hC5, 128'h0);
    scan(8'h87, 8'h8B, 128'h0);
    scan(8'h84, 8'h83, 128'h0);
    scan(8'h85, 8'h07, 128'h0);
    scan(8'h8B, 8'h09, 128'h0);
    scan(8'h88, 8'h0B, 128'h0A5C);
    tally_and_finish();
  end
endmodule
